// file: logic/grb_bank.sv
// Contract
// R1: Command and status bytes are numbered from zero, first register at byte zero.
// R2: Multi-byte values are little-endian, least significant byte at lowest address.
// R3: Shared memory split into writable command area and readable status area.
// R4: Clearing activation resets the gripper and clears fault status.
// R5: Controller sets activation first and keeps it set afterwards.
// R6: Rising activation starts calibration motion against the mechanical stops.
// R7: Go-to set drives fingers toward target with speed and force; clear stops.
// R8: No motion except activation, auto-release, or go-to set.
// R9: Auto-release moves slowly until all axes reach their mechanical limit.
// R10: After auto-release finishes, signal fault and refuse motion until reactivated.
// R11: Auto-release overrides every command bit except activation.
// R12: Release direction: 0 closes, else opens; sampled when auto-release starts.
// R13: Position byte 0x00 fully open, 0xFF fully closed.
// R14: Writing the position byte stores target only, no motion.
// R15: Speed byte applied live, 0x00 minimum to 0xFF at 100 mm/s; no motion.
// R16: Speed zero still gives minimum speed of about 13 mm/s.
// R17: Force byte sets maximum motor current during motion.
// R18: Current over force limit in motion stops fingers, reports object.
// R19: Controller writes zero to reserved command bytes 6 to 15.
// R20: Status echoes the received position request.
// R21: Status reports actual finger position from encoders.
// R22: Status byte 0 echoes activation in bit 0 and go-to in bit 3.
// R23: Motion status 0 in reset/release, 1 activating, 3 activated.
// R24: Fault 0x07 on action without activation, 0x0F after auto-release.
// R25: Object status 1 contact opening, 2 contact closing, 3 at target.
// R26: Reserved command bits ignored; reserved status bits read zero.
//
// Gripper command/status register bank with a small motion sequencer.
// Assumes byte-wide synchronous host access; encoder position and motor current come in from outside.
`timescale 1ns/1ps
module grb_bank #(
    parameter int DEPTH      = 16,
    parameter int STEP_CYCLE = grb_pkg::STEP_CYCLES
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // Command area write port
    input  wire logic       cmd_wr,
    input  wire logic [3:0] cmd_addr,
    input  wire logic [7:0] cmd_wdata,
    // Command area read-back port
    input  wire logic [3:0] cmd_raddr,
    output logic      [7:0] cmd_rdata,
    // Status area read port
    input  wire logic [3:0] sts_addr,
    output logic      [7:0] sts_rdata,
    // Motor side
    input  wire logic [7:0] measured_position,
    input  wire logic [7:0] measured_current,
    input  wire logic       at_limit,
    output logic            motor_en,
    output logic            motor_close,
    output logic      [7:0] motor_speed_mms,
    output logic      [7:0] current_limit
);
    import grb_pkg::*;

    grb_state_t state_ff, nxt_state;
    logic [7:0] action_ff, position_ff, speed_ff, force_ff;
    logic [1:0] object_ff, nxt_object;
    logic [3:0] fault_ff, nxt_fault;
    logic       rel_dir_ff, nxt_rel_dir;
    logic       act_prev_ff;
    logic [31:0] step_cnt_ff;

    // Command field decode
    wire logic wr_action   = cmd_wr && cmd_addr == ADDR_ACTION;            // R1
    wire logic activate_cmd     = action_ff[BIT_ACTIVATE];
    wire logic goto_cmd         = action_ff[BIT_GOTO];
    wire logic auto_release_cmd = action_ff[BIT_RELEASE];
    wire logic release_direction = action_ff[BIT_REL_DIR];
    wire logic act_rise    = activate_cmd && !act_prev_ff;                 // R6
    wire logic step_tick   = step_cnt_ff == 32'(STEP_CYCLE - 1);
    wire logic over_force  = measured_current > current_limit;             // R18
    wire logic at_target   = measured_position == position_ff;
    wire logic moving_close = position_ff > measured_position;             // R13
    wire logic any_action  = goto_cmd || auto_release_cmd;

    // Command memory copy for read-back; reserved bytes kept for host view
    grb_mem #(.DEPTH(DEPTH)) u_mem (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .wr_en   (cmd_wr),
        .wr_addr (cmd_addr),
        .wr_data (cmd_wdata),
        .rd_addr (cmd_raddr),
        .rd_data (cmd_rdata)
    );                                                                     // R3

    // Working copies of the command bytes; reserved action bits dropped
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            action_ff   <= RST_BYTE;
            position_ff <= RST_BYTE;
            speed_ff    <= RST_BYTE;
            force_ff    <= RST_BYTE;
            act_prev_ff <= 1'b0;
        end else begin
            act_prev_ff <= activate_cmd;
            if (wr_action) action_ff <= cmd_wdata & ACTION_MASK;           // R26
            if (cmd_wr && cmd_addr == ADDR_POSITION) position_ff <= cmd_wdata; // R14
            if (cmd_wr && cmd_addr == ADDR_SPEED) speed_ff <= cmd_wdata;   // R15
            if (cmd_wr && cmd_addr == ADDR_FORCE) force_ff <= cmd_wdata;   // R17
        end
    end

    // Step timer paces calibration and release progress
    always_ff @(posedge sys_clk) begin
        if (!rst_n || step_tick) begin
            step_cnt_ff <= '0;
        end else begin
            step_cnt_ff <= step_cnt_ff + 32'h00000001;
        end
    end

    // Sequencer: activation overrides all; release overrides go-to
    always_comb begin
        nxt_state   = state_ff;
        nxt_object  = object_ff;
        nxt_fault   = fault_ff;
        nxt_rel_dir = rel_dir_ff;
        if (!activate_cmd) begin
            nxt_state  = ST_IDLE;                                          // R4
            nxt_object = OBJ_MOVING;
            nxt_fault  = any_action ? FLT_NOT_ACT : FLT_NONE;              // R24
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (act_rise) begin
                        nxt_state = ST_CALIB;                              // R6
                        nxt_fault = FLT_NONE;
                    end
                end
                ST_CALIB: begin
                    if (auto_release_cmd) begin
                        nxt_state   = ST_RELEASE;                          // R11
                        nxt_rel_dir = release_direction;                   // R12
                        nxt_fault   = FLT_REL_BUSY;
                    end else if (at_limit && step_tick) begin
                        nxt_state = ST_READY;
                    end
                end
                ST_READY: begin
                    if (auto_release_cmd) begin
                        nxt_state   = ST_RELEASE;                          // R11
                        nxt_rel_dir = release_direction;                   // R12
                        nxt_fault   = FLT_REL_BUSY;
                    end else if (!goto_cmd) begin
                        nxt_object = OBJ_MOVING;                           // R7
                    end else if (object_ff == OBJ_MOVING) begin
                        if (at_target) begin
                            nxt_object = OBJ_AT_POS;                       // R25
                        end else if (over_force) begin
                            nxt_object = moving_close ? OBJ_CLOSING : OBJ_OPENING; // R18
                        end
                    end
                end
                ST_RELEASE: begin
                    if (at_limit && step_tick) begin
                        nxt_state = ST_LOCKED;                             // R9
                        nxt_fault = FLT_REL_DONE;                          // R10
                    end
                end
                ST_LOCKED: begin
                    nxt_fault = FLT_REL_DONE;                              // R10
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_ff   <= ST_IDLE;
            object_ff  <= OBJ_MOVING;
            fault_ff   <= FLT_NONE;
            rel_dir_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            object_ff  <= nxt_object;
            fault_ff   <= nxt_fault;
            rel_dir_ff <= nxt_rel_dir;
        end
    end

    // Motion drive: only calibration, release, or go-to while unsettled
    wire logic goto_move = state_ff == ST_READY && goto_cmd && !auto_release_cmd
                           && object_ff == OBJ_MOVING && !at_target;      // R7 R8
    // Routine motion stops on the edge that leaves the routine, so lock and idle never see a stray step
    wire logic routine_move = (state_ff == ST_CALIB || state_ff == ST_RELEASE)
                              && (nxt_state == ST_CALIB || nxt_state == ST_RELEASE); // R6 R9 R10
    wire logic nxt_motor_en = routine_move || (goto_move && !over_force);  // R18
    wire logic nxt_motor_close = state_ff == ST_RELEASE ? !rel_dir_ff :   // R12
                                 state_ff == ST_CALIB ? 1'b0 : moving_close;
    // Speed floor at 13 mm/s; 8-bit scale keeps the math small
    wire logic [15:0] speed_span = 16'(speed_ff) * 16'(SPEED_MAX_MMS - SPEED_MIN_MMS);
    wire logic [7:0]  speed_live = 8'(SPEED_MIN_MMS) + 8'(speed_span / 16'h00FF); // R15 R16
    wire logic [7:0]  nxt_speed  = state_ff == ST_READY ? speed_live : 8'(SPEED_MIN_MMS); // R9

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            motor_en        <= 1'b0;
            motor_close     <= 1'b0;
            motor_speed_mms <= RST_BYTE;
            current_limit   <= RST_BYTE;
        end else begin
            motor_en        <= nxt_motor_en;
            motor_close     <= nxt_motor_close;
            motor_speed_mms <= nxt_speed;
            current_limit   <= force_ff;                                   // R17
        end
    end

    // Status area composition; unlisted bytes and bits read zero
    wire logic [1:0] motion_state = state_ff == ST_CALIB ? MOT_ACTIVE :
                                    state_ff == ST_READY ? MOT_DONE : MOT_RESET; // R23
    wire logic activation_echo = activate_cmd;
    wire logic goto_echo       = goto_cmd;
    wire logic [7:0] status_byte = {object_ff, motion_state, goto_echo, 2'b00, activation_echo}; // R22 R26
    wire logic [7:0] fault_code  = {4'h0, fault_ff};
    wire logic [7:0] target_echo_value = position_ff;                      // R20
    wire logic [7:0] nxt_sts =
        sts_addr == ADDR_ACTION   ? status_byte :
        sts_addr == ADDR_FAULT    ? fault_code :
        sts_addr == ADDR_POSITION ? target_echo_value :
        sts_addr == ADDR_SPEED    ? measured_position :                    // R21
        sts_addr == ADDR_FORCE    ? measured_current : RST_BYTE;           // R26

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sts_rdata <= RST_BYTE;
        end else begin
            sts_rdata <= nxt_sts;                                          // R2
        end
    end

    // Checks
    a_deact_clears: assert property (@(posedge sys_clk) disable iff (!rst_n) // R4
        !activate_cmd && !any_action |=> fault_ff == FLT_NONE && state_ff == ST_IDLE)
        else $error("deactivation did not reset");
    a_rise_calib: assert property (@(posedge sys_clk) disable iff (!rst_n) // R6
        act_rise && state_ff == ST_IDLE |=> state_ff == ST_CALIB)
        else $error("no calibration after activation");
    a_no_idle_motion: assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
        state_ff == ST_READY && !goto_cmd |=> !motor_en)
        else $error("motion without go-to");
    a_release_wins: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
        activate_cmd && auto_release_cmd && (state_ff == ST_READY || state_ff == ST_CALIB)
        |=> state_ff == ST_RELEASE)
        else $error("release did not override");
    a_locked_fault: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
        state_ff == ST_LOCKED |-> fault_ff == FLT_REL_DONE && !motor_en)
        else $error("locked state without fault");
    a_not_act_fault: assert property (@(posedge sys_clk) disable iff (!rst_n) // R24
        !activate_cmd && goto_cmd |=> fault_ff == FLT_NOT_ACT)
        else $error("missing not-activated fault");
    a_force_stop: assert property (@(posedge sys_clk) disable iff (!rst_n) // R18
        goto_move && over_force |=> !motor_en)
        else $error("over force did not stop");
    a_echo_pos: assert property (@(posedge sys_clk) disable iff (!rst_n) // R20
        sts_addr == ADDR_POSITION ##1 $stable(position_ff) |-> sts_rdata == position_ff)
        else $error("position echo wrong");
    a_speed_floor: assert property (@(posedge sys_clk) disable iff (!rst_n) // R16
        motor_speed_mms >= 8'(SPEED_MIN_MMS) || !$past(rst_n))
        else $error("speed under floor");
    a_status_echo: assert property (@(posedge sys_clk) disable iff (!rst_n) // R22
        sts_addr == ADDR_ACTION && !cmd_wr |=> sts_rdata[BIT_ACTIVATE] == activate_cmd
                                              && sts_rdata[BIT_GOTO] == goto_cmd)
        else $error("command echo wrong");
    a_release_slow: assert property (@(posedge sys_clk) disable iff (!rst_n) // R9
        state_ff == ST_RELEASE |=> motor_speed_mms == 8'(SPEED_MIN_MMS))
        else $error("release not at slow speed");
    c_calib_done: cover property (@(posedge sys_clk) state_ff == ST_CALIB ##1 state_ff == ST_READY);
    c_release: cover property (@(posedge sys_clk) state_ff == ST_RELEASE ##1 state_ff == ST_LOCKED);
    c_object: cover property (@(posedge sys_clk) object_ff == OBJ_CLOSING);
    c_at_pos: cover property (@(posedge sys_clk) object_ff == OBJ_AT_POS);
endmodule

// file: logic/grb_mem.sv
// Small byte memory holding the command area bytes, registered read port.
// Assumes a single synchronous clock and active-low synchronous reset.
`timescale 1ns/1ps
module grb_mem #(
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    // Write port
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [7:0]               wr_data,
    // Read port
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic      [7:0]               rd_data
);
    import grb_pkg::*;
    logic [7:0] mem_ff [DEPTH];

    // Storage cleared on reset so that reads are defined
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_byte
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    mem_ff[g] <= RST_BYTE;
                end else if (wr_en && wr_addr == g) begin
                    mem_ff[g] <= wr_data;
                end
            end
        end
    endgenerate

    // Read data registered
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rd_data <= RST_BYTE;
        end else begin
            rd_data <= mem_ff[rd_addr];
        end
    end
endmodule

// file: logic/grb_pkg.sv
// Package for the gripper command and status register bank.
// Assumes one 40 MHz clock; byte-wide shared memory of 16 command and 16 status bytes.
package grb_pkg;
    // Byte addresses, numbered from zero, least significant byte lowest
    localparam logic [3:0] ADDR_ACTION   = 4'h0;
    localparam logic [3:0] ADDR_FAULT    = 4'h2;
    localparam logic [3:0] ADDR_POSITION = 4'h3;
    localparam logic [3:0] ADDR_SPEED    = 4'h4;
    localparam logic [3:0] ADDR_FORCE    = 4'h5;
    // Action request / gripper status bit positions
    localparam int BIT_ACTIVATE  = 0;
    localparam int BIT_GOTO      = 3;
    localparam int BIT_RELEASE   = 4;
    localparam int BIT_REL_DIR   = 5;
    localparam int POS_MOTION_LO = 4;
    localparam int POS_OBJECT_LO = 6;
    // Writable-bit mask of the action request byte
    localparam logic [7:0] ACTION_MASK = 8'h39;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Motion status codes
    localparam logic [1:0] MOT_RESET  = 2'h0;
    localparam logic [1:0] MOT_ACTIVE = 2'h1;
    localparam logic [1:0] MOT_DONE   = 2'h3;
    // Object status codes
    localparam logic [1:0] OBJ_MOVING  = 2'h0;
    localparam logic [1:0] OBJ_OPENING = 2'h1;
    localparam logic [1:0] OBJ_CLOSING = 2'h2;
    localparam logic [1:0] OBJ_AT_POS  = 2'h3;
    // Fault codes
    localparam logic [3:0] FLT_NONE     = 4'h0;
    localparam logic [3:0] FLT_NOT_ACT  = 4'h7;
    localparam logic [3:0] FLT_REL_BUSY = 4'hB;
    localparam logic [3:0] FLT_REL_DONE = 4'hF;
    // Speed: 13 mm/s floor, 100 mm/s ceiling
    localparam int SPEED_MIN_MMS = 13;
    localparam int SPEED_MAX_MMS = 100;
    // Clock and step timing
    localparam int CLK_HZ       = 40_000_000;
    localparam int STEP_TIME_US = 1000;
    localparam int STEP_CYCLES  = CLK_HZ / 1_000_000 * STEP_TIME_US;
    // Controller states
    typedef enum logic [4:0] {
        ST_IDLE    = 5'b00001,
        ST_CALIB   = 5'b00010,
        ST_READY   = 5'b00100,
        ST_RELEASE = 5'b01000,
        ST_LOCKED  = 5'b10000
    } grb_state_t;
endpackage

// file: verif/grb_ctl_model.sv
// Controller-side model: byte writes into the command area, reads of both areas.
// Assumes the bank takes a write on a rising sys_clk and answers a read one cycle later.
`timescale 1ns/1ps
module grb_ctl_model (
    // Clock
    input  wire logic       sys_clk,
    // Command area writes
    output logic            cmd_wr,
    output logic      [3:0] cmd_addr,
    output logic      [7:0] cmd_wdata,
    // Read addresses and answers
    output logic      [3:0] cmd_raddr,
    output logic      [3:0] sts_addr,
    input  wire logic [7:0] cmd_rdata,
    input  wire logic [7:0] sts_rdata
);
    // Quiet bus from time zero
    initial begin
        cmd_wr    = 1'b0;
        cmd_addr  = 4'h0;
        cmd_wdata = 8'hA5;
        cmd_raddr = 4'h0;
        sts_addr  = 4'h0;
    end

    // One whole byte per strobe, addressed from zero, so byte order never arises
    task automatic write_byte(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        cmd_wr    <= 1'b1;
        cmd_addr  <= a;
        cmd_wdata <= d;
        @(posedge sys_clk);
        cmd_wr    <= 1'b0;
        // Released data turns to garbage so a stale byte cannot pass for a write
        cmd_wdata <= ~d;
    endtask

    // Same address on both read ports; answer taken once the registered output has landed
    task automatic read_both(input logic [3:0] a, output logic [7:0] sts, output logic [7:0] cmd);
        @(posedge sys_clk);
        sts_addr  <= a;
        cmd_raddr <= a;
        @(posedge sys_clk);
        @(posedge sys_clk);
        #1;
        sts = sts_rdata;
        cmd = cmd_rdata;
    endtask
endmodule

// file: verif/gripper_command_register_bank_test.sv
// Self-checking bench for the gripper command/status bank.
// Assumes a shortened step tick; the bench plays the motor side, the model the controller.
`timescale 1ns/1ps
module gripper_command_register_bank_test;
    import grb_pkg::*;
    localparam int STEP = 4;
    typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] s;} grb_row_t;
    logic       sys_clk, rst_n, cmd_wr, at_limit, motor_en, motor_close;
    logic [3:0] cmd_addr, cmd_raddr, sts_addr;
    logic [7:0] cmd_wdata, cmd_rdata, sts_rdata, measured_position, measured_current;
    logic [7:0] motor_speed_mms, current_limit, sv, cv;
    int         mismatches, check_count;
    // Plain register traffic: address, data written, status byte expected at that address
    grb_row_t   rows [8] = '{'{4'h3, 8'hA5, 8'hA5}, '{4'h4, 8'h00, 8'h20}, '{4'h5, 8'hC3, 8'h00},
                             '{4'h1, 8'hFF, 8'h00}, '{4'h2, 8'hFF, 8'h00}, '{4'h6, 8'h00, 8'h00},
                             '{4'hF, 8'h00, 8'h00}, '{4'h0, 8'hC6, 8'h00}};

    grb_bank #(.DEPTH(16), .STEP_CYCLE(STEP)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .cmd_wr(cmd_wr), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_raddr(cmd_raddr), .cmd_rdata(cmd_rdata), .sts_addr(sts_addr), .sts_rdata(sts_rdata),
        .measured_position(measured_position), .measured_current(measured_current), .at_limit(at_limit),
        .motor_en(motor_en), .motor_close(motor_close), .motor_speed_mms(motor_speed_mms),
        .current_limit(current_limit));
    grb_ctl_model u_ctl (
        .sys_clk(sys_clk), .cmd_wr(cmd_wr), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_raddr(cmd_raddr), .sts_addr(sts_addr), .cmd_rdata(cmd_rdata), .sts_rdata(sts_rdata));

    // 40 MHz clock
    initial sys_clk = 1'b0;
    always #12.5 sys_clk = ~sys_clk;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string n);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // Polls a status byte; bounded so a stuck sequencer ends as a mismatch, not a hang
    task automatic expect_sts(input logic [3:0] a, input logic [7:0] e, input string n);
        int i;
        i = 0;
        u_ctl.read_both(a, sv, cv);
        while (sv !== e && i < 40) begin
            u_ctl.read_both(a, sv, cv);
            i++;
        end
        chk(sv, e, n);
    endtask

    task automatic motor_side(input logic lim, input logic [7:0] pos, input logic [7:0] cur);
        @(posedge sys_clk);
        at_limit          <= lim;
        measured_position <= pos;
        measured_current  <= cur;
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog, far beyond the few hundred cycles the sequence needs
    initial begin
        repeat (40000) @(posedge sys_clk);
        mismatches++;
        test_done();
    end

    initial begin
        rst_n             = 1'b0;
        at_limit          = 1'b0;
        measured_position = 8'h20;
        measured_current  = 8'h00;
        mismatches        = 0;
        check_count       = 0;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        // Reset image of the whole status and command areas
        for (int a = 0; a < 16; a++) begin
            u_ctl.read_both(a[3:0], sv, cv);
            chk(sv, (a == 4) ? 8'h20 : 8'h00, "status after reset");
            chk(cv, 8'h00, "command after reset");
        end
        chk({7'h00, motor_en}, 8'h00, "motor_en after reset");
        // Table of plain writes; none of them may move the fingers
        foreach (rows[i]) begin
            u_ctl.write_byte(rows[i].a, rows[i].d);
            u_ctl.read_both(rows[i].a, sv, cv);
            chk(cv, rows[i].d, "command readback");
            chk(sv, rows[i].s, "status byte");
            chk({7'h00, motor_en}, 8'h00, "motor_en on write");
        end
        chk(current_limit, 8'hC3, "current limit");
        // Go-to without activation
        u_ctl.write_byte(ADDR_ACTION, 8'h08);
        expect_sts(ADDR_FAULT, {4'h0, FLT_NOT_ACT}, "fault not active");
        chk({7'h00, motor_en}, 8'h00, "motor_en unactivated");
        u_ctl.write_byte(ADDR_ACTION, 8'h00);
        expect_sts(ADDR_FAULT, 8'h00, "fault cleared");
        // Activation and calibration against the stops
        u_ctl.write_byte(ADDR_ACTION, 8'h01);
        expect_sts(ADDR_ACTION, 8'h11, "activating");
        chk({7'h00, motor_en}, 8'h01, "calibration motion");
        motor_side(1'b1, 8'h20, 8'h00);
        expect_sts(ADDR_ACTION, 8'h31, "activated");
        chk({7'h00, motor_en}, 8'h00, "idle when ready");
        motor_side(1'b0, 8'h20, 8'h00);
        // Speed only drives the motor once activated; byte 4 still holds zero here
        chk(motor_speed_mms, SPEED_MIN_MMS[7:0], "speed floor");
        u_ctl.write_byte(ADDR_SPEED, 8'hFF);
        u_ctl.read_both(ADDR_SPEED, sv, cv);
        chk(motor_speed_mms, SPEED_MAX_MMS[7:0], "speed ceiling");
        chk({7'h00, motor_en}, 8'h00, "motor_en on speed");
        // Go-to closing, then a contact stop
        u_ctl.write_byte(ADDR_POSITION, 8'h80);
        u_ctl.write_byte(ADDR_ACTION, 8'h09);
        expect_sts(ADDR_ACTION, 8'h39, "goto echo");
        chk({6'h00, motor_en, motor_close}, 8'h03, "closing motion");
        motor_side(1'b0, 8'h20, 8'hFF);
        expect_sts(ADDR_ACTION, 8'hB9, "contact closing");
        chk({7'h00, motor_en}, 8'h00, "stopped on contact");
        expect_sts(ADDR_FORCE, 8'hFF, "current echo");
        u_ctl.write_byte(ADDR_ACTION, 8'h01);
        motor_side(1'b0, 8'h80, 8'h00);
        expect_sts(ADDR_ACTION, 8'h31, "goto cleared");
        u_ctl.write_byte(ADDR_ACTION, 8'h09);
        expect_sts(ADDR_ACTION, 8'hF9, "at target");
        chk({7'h00, motor_en}, 8'h00, "stopped at target");
        // Opening contact
        u_ctl.write_byte(ADDR_ACTION, 8'h01);
        u_ctl.write_byte(ADDR_POSITION, 8'h10);
        motor_side(1'b0, 8'h80, 8'hFF);
        u_ctl.write_byte(ADDR_ACTION, 8'h09);
        expect_sts(ADDR_ACTION, 8'h79, "contact opening");
        motor_side(1'b0, 8'h80, 8'h00);
        // Closing auto-release overriding a live go-to
        u_ctl.write_byte(ADDR_ACTION, 8'h19);
        expect_sts(ADDR_FAULT, {4'h0, FLT_REL_BUSY}, "release running");
        chk({6'h00, motor_en, motor_close}, 8'h03, "release closing");
        chk(motor_speed_mms, SPEED_MIN_MMS[7:0], "release slow");
        motor_side(1'b1, 8'h80, 8'h00);
        expect_sts(ADDR_FAULT, {4'h0, FLT_REL_DONE}, "release done");
        motor_side(1'b0, 8'h80, 8'h00);
        u_ctl.write_byte(ADDR_ACTION, 8'h09);
        u_ctl.read_both(ADDR_FAULT, sv, cv);
        chk({7'h00, motor_en}, 8'h00, "locked refuses motion");
        chk(sv, {4'h0, FLT_REL_DONE}, "fault held");
        u_ctl.write_byte(ADDR_ACTION, 8'h00);
        expect_sts(ADDR_FAULT, 8'h00, "deactivate clears");
        expect_sts(ADDR_ACTION, 8'h00, "status reset");
        u_ctl.write_byte(ADDR_ACTION, 8'h01);
        motor_side(1'b1, 8'h80, 8'h00);
        expect_sts(ADDR_ACTION, 8'h31, "reactivated");
        motor_side(1'b0, 8'h80, 8'h00);
        // Opening release: direction set first, then changed mid-release
        u_ctl.write_byte(ADDR_ACTION, 8'h21);
        u_ctl.write_byte(ADDR_ACTION, 8'h31);
        expect_sts(ADDR_FAULT, {4'h0, FLT_REL_BUSY}, "open release");
        u_ctl.write_byte(ADDR_ACTION, 8'h11);
        u_ctl.read_both(ADDR_ACTION, sv, cv);
        chk({6'h00, motor_en, motor_close}, 8'h02, "direction sampled");
        // Second reset in mid-motion
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        u_ctl.read_both(ADDR_ACTION, sv, cv);
        chk(sv, 8'h00, "status after reset");
        chk(cv, 8'h00, "command after reset");
        chk({7'h00, motor_en}, 8'h00, "motor_en after reset");
        test_done();
    end
endmodule
